// ===== hw/msd_pkg.sv
// Constants and encodings for the memory space decoder.
// Assumes byte-wide register-file and program-memory spaces of the core.
package msd_pkg;
    localparam int          MSD_RF_AW       = 12;
    localparam int          MSD_PM_AW       = 16;
    localparam int          MSD_FL_AW       = 14;
    localparam int          MSD_RAM_AW      = 9;
    localparam int          MSD_CTL_AW      = 8;
    localparam int          MSD_INFO_AW     = 9;
    localparam int          MSD_ID_LEN      = 20;
    localparam logic [11:0] MSD_RAM_LAST    = 12'h1FF;
    localparam logic [11:0] MSD_CTL_BASE    = 12'hF00;
    localparam logic [15:0] MSD_OPT_BASE    = 16'h0000;
    localparam logic [15:0] MSD_RSTV_BASE   = 16'h0002;
    localparam logic [15:0] MSD_SYSX_BASE   = 16'h0004;
    localparam logic [15:0] MSD_IRQV_BASE   = 16'h0008;
    localparam logic [15:0] MSD_CODE_BASE   = 16'h0040;
    localparam logic [15:0] MSD_FLASH_LAST  = 16'h3FFF;
    localparam logic [15:0] MSD_INFO_BASE   = 16'hFE00;
    localparam logic [8:0]  MSD_ID_FIRST    = 9'h040;
    localparam logic [8:0]  MSD_ID_LAST     = 9'h05F;
    localparam logic [7:0]  MSD_UNIMPL_BYTE = 8'hFF;
    localparam logic [7:0]  MSD_GAP_BYTE    = 8'h00;
    localparam logic [7:0]  MSD_RSVD_BYTE   = 8'h00;
    localparam int          MSD_INFO_EN_BIT = 7;
    localparam logic [7:0]  MSD_RST_BYTE    = 8'h00;

    // Register-file regions, one-hot.
    typedef enum logic [2:0] {
        MSD_RF_RAM  = 3'b001,
        MSD_RF_CTL  = 3'b010,
        MSD_RF_NONE = 3'b100
    } msd_rf_region_t;

    // Source of program-memory read data, one-hot.
    typedef enum logic [2:0] {
        MSD_SRC_FLASH = 3'b001,
        MSD_SRC_ONES  = 3'b010,
        MSD_SRC_INFO  = 3'b100
    } msd_pm_src_t;

    // Program-memory areas, one-hot.
    typedef enum logic [5:0] {
        MSD_PA_OPT  = 6'b000001,
        MSD_PA_RSTV = 6'b000010,
        MSD_PA_SYSX = 6'b000100,
        MSD_PA_IRQV = 6'b001000,
        MSD_PA_CODE = 6'b010000,
        MSD_PA_NONE = 6'b100000
    } msd_pm_area_t;
endpackage

// ===== hw/msd_info_if.sv
// Read port between the decoder and its information-area store.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface msd_info_if;
    logic       rd_en;
    logic [8:0] addr;
    logic [7:0] rdata;

    modport decoder (output rd_en, output addr, input rdata);
    modport store   (input rd_en, input addr, output rdata);
endinterface

// ===== hw/msd_info_rom.sv
// Read-only information area: identifier bytes, reserved bytes elsewhere.
// Assumes the decoder only asserts rd_en for overlaid reads.
`timescale 1ns/1ps
module msd_info_rom
    import msd_pkg::*;
#(
    // Arbitrary identifier value, left justified, first char in top byte.
    parameter logic [8*MSD_ID_LEN-1:0] PART_ID = "MSD-GENERIC-PART-01 "
)
(
    input  wire logic   clock,
    input  wire logic   rstn,
    msd_info_if.store   port
);
    logic [7:0] id_byte [MSD_ID_LEN];
    logic [7:0] next_rdata;

    // Unpack the identifier; trailing spaces become nulls as padding.
    genvar gi;
    generate
        for (gi = 0; gi < MSD_ID_LEN; gi++)
        begin : g_id
            assign id_byte[gi] =
                (PART_ID[8*(MSD_ID_LEN-gi)-1 -: 8] == 8'h20) ?
                8'h00 : PART_ID[8*(MSD_ID_LEN-gi)-1 -: 8];
        end
    endgenerate

    // Identifier window, null fill after it, reserved bytes elsewhere.
    always_comb
    begin
        next_rdata = MSD_RSVD_BYTE;
        if (port.addr >= MSD_ID_FIRST && port.addr <= MSD_ID_LAST)
        begin
            if (port.addr - MSD_ID_FIRST < 9'(MSD_ID_LEN))
                next_rdata = id_byte[5'(port.addr - MSD_ID_FIRST)];
            else
                next_rdata = 8'h00;
        end
    end

    // Registered read; there is no write path at all.
    always_ff @(posedge clock)
    begin
        if (!rstn)
            port.rdata <= MSD_RST_BYTE;
        else if (port.rd_en)
            port.rdata <= next_rdata;
    end
endmodule

// ===== hw/msd_decoder.sv
// Address decoder for the register-file and program-memory spaces.
// Assumes RAM, control page and flash answer one cycle after a strobe,
// and that the page-select register lives in the flash controller.
`timescale 1ns/1ps
module msd_decoder
    import msd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // Register-file requests from the core.
    input  wire logic                  rf_req,
    input  wire logic                  rf_we,
    input  wire logic [MSD_RF_AW-1:0]  rf_addr,
    input  wire logic [7:0]            rf_wdata,
    output logic                       rf_rvalid,
    output logic [7:0]                 rf_rdata,
    output msd_rf_region_t             rf_region,

    // On-chip RAM port.
    output logic                       ram_en,
    output logic                       ram_we,
    output logic [MSD_RAM_AW-1:0]      ram_addr,
    output logic [7:0]                 ram_wdata,
    input  wire logic [7:0]            ram_rdata,

    // Control-register page port.
    output logic                       ctl_en,
    output logic                       ctl_we,
    output logic [MSD_CTL_AW-1:0]      ctl_addr,
    output logic [7:0]                 ctl_wdata,
    input  wire logic [7:0]            ctl_rdata,

    // Program-memory requests from the core or the debugger.
    input  wire logic                  pm_req,
    input  wire logic                  pm_we,
    input  wire logic                  pm_fetch,
    input  wire logic                  on_chip_debugger,
    input  wire logic [MSD_PM_AW-1:0]  pm_addr,
    input  wire logic [7:0]            pm_wdata,
    input  wire logic [7:0]            flash_page_sel,
    output logic                       pm_rvalid,
    output logic [7:0]                 pm_rdata,
    output msd_pm_area_t               pm_area,

    // Flash array port.
    output logic                       flash_en,
    output logic                       flash_we,
    output logic [MSD_FL_AW-1:0]       flash_addr,
    output logic [7:0]                 flash_wdata,
    input  wire logic [7:0]            flash_rdata,

    // Data-memory space select, never asserted.
    output logic                       dm_sel
);

    // The register-file space is twelve bits wide. RAM starts at
    // address zero and runs to the last implemented byte, the control
    // page fills the top 256 bytes, and everything between is a gap.
    // Every address lands in exactly one region, so at most one port
    // strobe is high for any request.

    // Reserved holes inside the control page are not filtered here.
    // The page decides what such an access does, so a new peripheral
    // needs no change in this block.

    // A gap write strobes nothing and so changes no state. A gap read
    // still answers on time with a fixed byte, because a core that
    // waits for its answer must never hang on a stray pointer.

    // The program space is sixteen bits wide, but only the low 16 KB
    // are backed by flash. Reads above the array answer all ones, as
    // an erased byte would. The flash address is only the low fourteen
    // bits of the request, so a write above the array must never be
    // strobed, or it would alias onto a real flash byte.

    // The first 64 bytes of flash hold the option bytes, the reset
    // vector, the system exception vectors and the interrupt vectors;
    // code follows. The area of each request is reported on pm_area.

    // With bit 7 of the page-select register set, the top 512 bytes of
    // the program space show the information area to data reads, from
    // constant loads and from the debugger alike. Fetches never see it,
    // so a fetch from the top of the map still answers all ones while software
    // reads the area. The area has no write path; a write aimed at it
    // is dropped like any other write above the array.

    // A read, counted in rising edges from the one that takes it:
    // before edge 0 the strobe of the selected port is already high;
    // at edge 0 the port registers its data and the source is noted;
    // at edge 1 that data is taken into the answer register;
    // at edge 2 rvalid is seen high for one cycle with the data.
    // Requests may come back to back and answer in order. A write
    // takes effect at edge 0 and produces no answer.

    // The core's data-memory space is unused here, so its select is
    // tied low rather than left undriven.

    // Classify a register-file address into exactly one region.
    function automatic msd_rf_region_t rf_decode(
        input logic [MSD_RF_AW-1:0] a
    );
        msd_rf_region_t r;
        r = MSD_RF_NONE;
        if (a >= MSD_CTL_BASE)
            r = MSD_RF_CTL;
        else if (a <= MSD_RAM_LAST)
            r = MSD_RF_RAM;
        return r;
    endfunction

    // Areas are tested from the top down, so each test needs only a
    // lower bound and the first match wins.

    // Classify a program-memory address into its fixed area.
    function automatic msd_pm_area_t pm_decode(
        input logic [MSD_PM_AW-1:0] a
    );
        msd_pm_area_t r;
        r = MSD_PA_NONE;
        if (a > MSD_FLASH_LAST)
            r = MSD_PA_NONE;
        else if (a >= MSD_CODE_BASE)
            r = MSD_PA_CODE;
        else if (a >= MSD_IRQV_BASE)
            r = MSD_PA_IRQV;
        else if (a >= MSD_SYSX_BASE)
            r = MSD_PA_SYSX;
        else if (a >= MSD_RSTV_BASE)
            r = MSD_PA_RSTV;
        else if (a >= MSD_OPT_BASE)
            r = MSD_PA_OPT;
        return r;
    endfunction

    // Used by both the strobe and the source logic, which must agree.

    // True when the address is backed by the flash array.
    function automatic logic pm_in_flash(
        input logic [MSD_PM_AW-1:0] a
    );
        return a <= MSD_FLASH_LAST;
    endfunction

    msd_info_if info ();

    msd_rf_region_t rf_sel;
    msd_pm_area_t   pm_sel_area;
    msd_pm_src_t    next_pm_src;
    msd_rf_region_t rf_rd_region;
    msd_pm_src_t    pm_src;
    logic           rf_rd_pend;
    logic           pm_rd_pend;
    logic           info_en;
    logic           info_hit;
    logic           rf_read;
    logic           pm_read;

    // Decode the current requests.
    assign rf_sel      = rf_decode(rf_addr);
    assign pm_sel_area = pm_decode(pm_addr);
    assign rf_read     = rf_req && !rf_we;
    assign pm_read     = pm_req && !pm_we;

    // The overlay enable is taken straight from the page-select register.
    assign info_en  = flash_page_sel[MSD_INFO_EN_BIT];
    assign info_hit = info_en && (pm_addr >= MSD_INFO_BASE);

    // The data-memory space has nothing behind it on this device.
    assign dm_sel = 1'b0;

    // The port strobes are decoded straight from the request, with no
    // register, so that RAM and control registers see the access in the
    // same cycle as the core issues it.

    // RAM strobes: only RAM-region accesses reach the array.
    // A write is issued only for a destination operand.
    always_comb
    begin
        ram_en    = rf_req && (rf_sel == MSD_RF_RAM);
        ram_we    = ram_en && rf_we;
        ram_addr  = rf_addr[MSD_RAM_AW-1:0];
        ram_wdata = rf_wdata;
    end

    // Control-page strobes. Reserved control addresses are passed on
    // unchanged; their read data is whatever the page returns.
    always_comb
    begin
        ctl_en    = rf_req && (rf_sel == MSD_RF_CTL);
        ctl_we    = ctl_en && rf_we;
        ctl_addr  = rf_addr[MSD_CTL_AW-1:0];
        ctl_wdata = rf_wdata;
    end

    // A data read of the overlaid range must not strobe the flash,
    // even though the range lies above the array today; a larger
    // array would otherwise answer on both paths at once.

    // Flash strobes. Writes outside the array never leave the decoder,
    // and writes into the overlaid range reach no store of the info area.
    always_comb
    begin
        flash_en    = pm_req && pm_in_flash(pm_addr) &&
                      !(pm_read && !pm_fetch && info_hit);
        flash_we    = flash_en && pm_we;
        flash_addr  = pm_addr[MSD_FL_AW-1:0];
        flash_wdata = pm_wdata;
    end

    // Information-area read port: data reads only, never fetches.
    always_comb
    begin
        info.rd_en = pm_read && !pm_fetch && info_hit;
        info.addr  = pm_addr[MSD_INFO_AW-1:0];
    end

    // The source is chosen in the request cycle and carried with the
    // read, because the address has moved on when the data is taken.

    // Choose where program read data will come from.
    // Fetches ignore the overlay so code keeps running from flash.
    always_comb
    begin
        next_pm_src = MSD_SRC_ONES;
        if (info_hit && !pm_fetch)
            next_pm_src = MSD_SRC_INFO;
        else if (pm_in_flash(pm_addr))
            next_pm_src = MSD_SRC_FLASH;
        if (info_hit && !pm_fetch && on_chip_debugger)
            next_pm_src = MSD_SRC_INFO;
    end

    // The store registers its byte only when a data read hits the
    // overlay, so the byte stays put while fetches and flash reads
    // pass through the same addresses.

    // Information-area store with registered read data.
    msd_info_rom u_info (
        .clock (clock),
        .rstn  (rstn),
        .port  (info.store)
    );

    // The read path of each space is two register stages deep. The
    // first stage follows the ports, which answer one cycle after the
    // strobe; the second gives the core a registered answer with no
    // path from the port data straight to its inputs. Both stages run
    // every cycle, so back-to-back reads need no hold-off.

    // First stage of a register-file read: remember the region.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            rf_rd_pend   <= 1'b0;
            rf_rd_region <= MSD_RF_NONE;
        end
        else
        begin
            rf_rd_pend   <= rf_read;
            rf_rd_region <= rf_sel;
        end
    end

    // Second stage: register the data of the region that answered.
    // The gap returns a fixed byte so the bus never floats, although
    // software may not rely on its value.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            rf_rvalid <= 1'b0;
            rf_rdata  <= MSD_RST_BYTE;
            rf_region <= MSD_RF_NONE;
        end
        else
        begin
            rf_rvalid <= rf_rd_pend;
            if (rf_rd_pend)
            begin
                rf_region <= rf_rd_region;
                case (rf_rd_region)
                    MSD_RF_RAM:  rf_rdata <= ram_rdata;
                    MSD_RF_CTL:  rf_rdata <= ctl_rdata;
                    MSD_RF_NONE: rf_rdata <= MSD_GAP_BYTE;
                    default:     rf_rdata <= MSD_GAP_BYTE;
                endcase
            end
        end
    end

    // The program read path mirrors the register-file one. Its source
    // register is loaded on every cycle; only the pending flag says
    // whether the source belongs to a read.

    // First stage of a program read: remember the source.
    // The area is tracked for every request, writes included.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            pm_rd_pend <= 1'b0;
            pm_src     <= MSD_SRC_ONES;
        end
        else
        begin
            pm_rd_pend <= pm_read;
            pm_src     <= next_pm_src;
        end
    end

    // The area is reported for writes as well, so that protection
    // logic outside can refuse a write to the option bytes or vectors.

    // Area of the latest program request, held between requests.
    always_ff @(posedge clock)
    begin
        if (!rstn)
            pm_area <= MSD_PA_NONE;
        else if (pm_req)
            pm_area <= pm_sel_area;
    end

    // Second stage: register the selected program read data.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            pm_rvalid <= 1'b0;
            pm_rdata  <= MSD_RST_BYTE;
        end
        else
        begin
            pm_rvalid <= pm_rd_pend;
            if (pm_rd_pend)
            begin
                case (pm_src)
                    MSD_SRC_FLASH: pm_rdata <= flash_rdata;
                    MSD_SRC_INFO:  pm_rdata <= info.rdata;
                    MSD_SRC_ONES:  pm_rdata <= MSD_UNIMPL_BYTE;
                    default:       pm_rdata <= MSD_UNIMPL_BYTE;
                endcase
            end
        end
    end
endmodule

// ===== sim/msd_mem_model.sv
// Behavioural RAM, control page and flash array behind the decoder.
// Assumes one strobe per port per cycle, data due on the next cycle.
`timescale 1ns/1ps
module msd_mem_model
(
    input  wire logic        clock,
    input  wire logic        ram_en,
    input  wire logic        ram_we,
    input  wire logic [8:0]  ram_addr,
    input  wire logic [7:0]  ram_wdata,
    output logic      [7:0]  ram_rdata,
    input  wire logic        ctl_en,
    input  wire logic        ctl_we,
    input  wire logic [7:0]  ctl_addr,
    input  wire logic [7:0]  ctl_wdata,
    output logic      [7:0]  ctl_rdata,
    input  wire logic        flash_en,
    input  wire logic        flash_we,
    input  wire logic [13:0] flash_addr,
    input  wire logic [7:0]  flash_wdata,
    output logic      [7:0]  flash_rdata
);
    logic [7:0] ram [512];
    logic [7:0] ctl [256];
    logic [7:0] fl  [16384];

    // Flash starts with a pattern so that neighbouring bytes differ, except the pair at 0x1FFF and 0x2000.
    initial
    begin
        for (int i = 0; i < 16384; i++)
            fl[i] = 8'(i) ^ 8'(i >> 6);
    end

    // Idle ports invert their last output each cycle, so a stale value is not read as good in the first idle cycle.
    always @(posedge clock)
    begin
        if (ram_en && ram_we) ram[ram_addr] <= ram_wdata;
        if (ctl_en && ctl_we) ctl[ctl_addr] <= ctl_wdata;
        if (flash_en && flash_we) fl[flash_addr] <= flash_wdata;
        ram_rdata   <= ram_en ? ram[ram_addr] : ~ram_rdata;
        ctl_rdata   <= ctl_en ? ctl[ctl_addr] : ~ctl_rdata;
        flash_rdata <= flash_en ? fl[flash_addr] : ~flash_rdata;
    end
endmodule

// ===== sim/msd_decoder_chk.sv
// Port checker for the memory space decoder.
// Assumes one clock domain and the synchronous active-low reset rstn.
`timescale 1ns/1ps
module msd_decoder_chk
    import msd_pkg::*;
(
    input  wire logic           clock,
    input  wire logic           rstn,
    input  wire logic           rf_req,
    input  wire logic           rf_we,
    input  wire logic [11:0]    rf_addr,
    input  wire logic           rf_rvalid,
    input  wire msd_rf_region_t rf_region,
    input  wire logic           ram_en,
    input  wire logic           ram_we,
    input  wire logic [8:0]     ram_addr,
    input  wire logic           ctl_en,
    input  wire logic           ctl_we,
    input  wire logic           pm_req,
    input  wire logic           pm_we,
    input  wire logic           pm_fetch,
    input  wire logic [15:0]    pm_addr,
    input  wire logic [7:0]     flash_page_sel,
    input  wire logic           pm_rvalid,
    input  wire logic [7:0]     pm_rdata,
    input  wire logic           flash_en,
    input  wire logic           dm_sel
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // Gap and overlay qualifiers shared by several properties.
    logic gap;
    logic ovl;
    assign gap = rf_addr > 12'h1FF && rf_addr < 12'hF00;
    assign ovl = flash_page_sel[7] && pm_addr >= 16'hFE00 && !pm_fetch;

    a_ctl_page_sel: assert property (rf_req && rf_addr >= 12'hF00
        |-> ctl_en && !ram_en) else $error("control page not selected");
    a_ram_select: assert property (rf_req && rf_addr <= 12'h1FF
        |-> ram_en && !ctl_en && ram_addr == rf_addr[8:0])
        else $error("RAM not selected");
    a_gap_quiet: assert property (rf_req && gap
        |-> !ram_en && !ctl_en) else $error("gap access strobed a port");
    a_gap_region: assert property (rf_req && !rf_we && gap
        |-> ##2 rf_rvalid && rf_region == MSD_RF_NONE)
        else $error("gap read region wrong");
    a_src_read: assert property (rf_req && !rf_we
        |-> ##2 rf_rvalid) else $error("read not answered");
    a_dst_write: assert property (rf_req && rf_we && !gap
        |-> ram_we || ctl_we) else $error("write not strobed");
    a_pm_ones: assert property (pm_req && !pm_we && !ovl
        && pm_addr > 16'h3FFF |-> ##2 pm_rvalid && pm_rdata == 8'hFF)
        else $error("unimplemented read not FF");
    a_pm_wr_drop: assert property (pm_req && pm_addr > 16'h3FFF
        |-> !flash_en) else $error("flash strobed beyond its size");
    a_ovl_answer: assert property (pm_req && !pm_we && ovl
        |-> ##2 pm_rvalid && pm_rdata != 8'hFF)
        else $error("overlay read not from info area");
    a_dm_idle: assert property (!dm_sel)
        else $error("data memory selected");

    c_ctl_read: cover property (rf_req && !rf_we && ctl_en);
    c_ovl_read: cover property (pm_req && ovl);
    c_pm_drop: cover property (pm_req && pm_we && pm_addr > 16'h3FFF);
endmodule

bind msd_decoder msd_decoder_chk msd_decoder_chk_inst (.clock, .rstn,
    .rf_req, .rf_we, .rf_addr, .rf_rvalid, .rf_region, .ram_en, .ram_we,
    .ram_addr, .ctl_en, .ctl_we, .pm_req, .pm_we, .pm_fetch, .pm_addr,
    .flash_page_sel, .pm_rvalid, .pm_rdata, .flash_en, .dm_sel);

// ===== sim/memory_space_decoder_test.sv
// Self-checking bench for the memory space decoder.
// Assumes the decoder holds the information store with its default value.
`timescale 1ns/1ps
module memory_space_decoder_test
    import msd_pkg::*;
;
    localparam logic [159:0] ID = "MSD-GENERIC-PART-01 ";
    logic clock, rstn, rf_req, rf_we, rf_rvalid, ram_en, ram_we, ctl_en;
    logic ctl_we, pm_req, pm_we, pm_fetch, on_chip_debugger, pm_rvalid;
    logic flash_en, flash_we, dm_sel;
    logic [11:0] rf_addr;
    logic [15:0] pm_addr, a;
    logic [8:0]  ram_addr;
    logic [7:0]  ctl_addr, rf_wdata, rf_rdata, ram_wdata, ram_rdata, ctl_wdata;
    logic [7:0]  ctl_rdata, pm_wdata, flash_page_sel, pm_rdata, flash_wdata;
    logic [7:0]  flash_rdata;
    logic [13:0] flash_addr, pe;
    logic [10:0] re;
    logic [31:0] seed = 32'h12;
    logic [31:0] r;
    msd_rf_region_t rf_region;
    msd_pm_area_t   pm_area;
    logic [10:0] rq[$];
    logic [13:0] pq[$];
    // One or two addresses per program area, with both ends of the flash array.
    logic [15:0] pm_pick [11] = '{16'h0000, 16'h0001, 16'h0002,
        16'h0004, 16'h0007, 16'h0008, 16'h003F, 16'h0040, 16'h3FFF,
        16'h4000, 16'hFFFF};
    int n_errors = 0;
    int n_checks = 0;

    msd_decoder msd_decoder_inst (.clock, .rstn, .rf_req, .rf_we, .rf_addr,
        .rf_wdata, .rf_rvalid, .rf_rdata, .rf_region, .ram_en, .ram_we,
        .ram_addr, .ram_wdata, .ram_rdata, .ctl_en, .ctl_we, .ctl_addr,
        .ctl_wdata, .ctl_rdata, .pm_req, .pm_we, .pm_fetch,
        .on_chip_debugger, .pm_addr, .pm_wdata, .flash_page_sel, .pm_rvalid,
        .pm_rdata, .pm_area, .flash_en, .flash_we, .flash_addr,
        .flash_wdata, .flash_rdata, .dm_sel);
    msd_mem_model msd_mem_model_inst (.clock, .ram_en, .ram_we, .ram_addr,
        .ram_wdata, .ram_rdata, .ctl_en, .ctl_we, .ctl_addr, .ctl_wdata,
        .ctl_rdata, .flash_en, .flash_we, .flash_addr, .flash_wdata,
        .flash_rdata);

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected area and byte of a flash-side read without overlay.
    function logic [13:0] exp_pm(input logic [15:0] x);
        logic [5:0] ar;
        ar = x < 16'h0002 ? 6'h01 : x < 16'h0004 ? 6'h02 : x < 16'h0008 ?
             6'h04 : x < 16'h0040 ? 6'h08 : x <= 16'h3FFF ? 6'h10 : 6'h20;
        return {ar, x <= 16'h3FFF ? x[7:0] ^ x[13:6] : 8'hFF};
    endfunction

    // Identifier bytes; trailing blanks of the string read back as nulls.
    function logic [7:0] info(input logic [8:0] o);
        logic [7:0] c;
        c = 8'h00;
        if (o >= 9'h040 && o < 9'h054) c = ID[8 * (83 - int'(o)) +: 8];
        return c == 8'h20 ? 8'h00 : c;
    endfunction

    task chk(input string w, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask

    task rf(input logic w, input logic [11:0] x, input logic [7:0] d,
            input logic [10:0] e);
        @(posedge clock);
        rf_req <= 1'b1;
        rf_we <= w;
        rf_addr <= x;
        rf_wdata <= d;
        if (!w) rq.push_back(e);
    endtask

    // Program requests are spaced so the area output cannot be overtaken.
    task pm(input logic w, f, g, input logic [15:0] x, input logic [7:0] d,
            input logic [13:0] e);
        @(posedge clock);
        pm_req <= 1'b1;
        pm_we <= w;
        pm_fetch <= f;
        on_chip_debugger <= g;
        pm_addr <= x;
        pm_wdata <= d;
        if (!w) pq.push_back(e);
        @(posedge clock);
        pm_req <= 1'b0;
        @(posedge clock);
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Answers are matched against the oldest note when they appear.
    always @(negedge clock)
    begin
        if (rstn === 1'b1 && rf_rvalid === 1'b1)
        begin
            re = rq.pop_front();
            chk("rf_rdata", re[7:0], rf_rdata);
            chk("rf_region", {5'h00, re[10:8]}, {5'h00, rf_region});
        end
        if (rstn === 1'b1 && pm_rvalid === 1'b1)
        begin
            pe = pq.pop_front();
            chk("pm_rdata", pe[7:0], pm_rdata);
            chk("pm_area", {2'h0, pe[13:8]}, {2'h0, pm_area});
        end
    end

    initial
    begin
        repeat (3000) @(posedge clock);
        n_errors++;
        end_of_test;
    end

    initial
    begin
        {rstn, rf_req, rf_we, pm_req, pm_we, pm_fetch} = 6'h00;
        {on_chip_debugger, rf_addr, pm_addr} = 29'h0;
        {rf_wdata, pm_wdata, flash_page_sel} = 24'h0;
        repeat (3) @(posedge clock);
        chk("dm_sel", 8'h00, {7'h00, dm_sel});
        rstn <= 1'b1;
        rf(1'b1, 12'h000, 8'h11, 11'h0);
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            a = i == 0 ? 16'h01FF : {7'h00, r[8:1], 1'b1}; // Keeps 000.
            rf(1'b1, a[11:0], r[23:16], 11'h0);
            rf(1'b0, a[11:0], 8'h00, {MSD_RF_RAM, r[23:16]});
        end
        rf(1'b1, 12'hF00, 8'hA5, 11'h0);
        rf(1'b1, 12'h200, 8'h3C, 11'h0);
        rf(1'b0, 12'hF00, 8'h00, {MSD_RF_CTL, 8'hA5});
        rf(1'b0, 12'h200, 8'h00, {MSD_RF_NONE, MSD_GAP_BYTE});
        rf(1'b0, 12'hEFF, 8'h00, {MSD_RF_NONE, MSD_GAP_BYTE});
        rf(1'b0, 12'h000, 8'h00, {MSD_RF_RAM, 8'h11});
        @(posedge clock);
        rf_req <= 1'b0;
        for (int k = 0; k < 11; k++)
        begin
            a = pm_pick[k];
            pm(1'b0, k[0], 1'b0, a, 8'h00, exp_pm(a));
        end
        pm(1'b1, 1'b0, 1'b0, 16'h0100, 8'h77, 14'h0);
        pm(1'b1, 1'b0, 1'b0, 16'hC100, 8'h99, 14'h0);
        pm(1'b0, 1'b0, 1'b0, 16'h0100, 8'h00, {6'h10, 8'h77});
        r = rnd();
        flash_page_sel <= {1'b1, r[6:0]};
        pm(1'b1, 1'b0, 1'b1, 16'hFE41, 8'h00, 14'h0);
        for (int k = 9'h03E; k < 9'h062; k++)
        begin
            a = 16'hFE00 + 16'(k);
            pm(1'b0, 1'b0, k[0], a, 8'h00, {6'h20, info(a[8:0])});
        end
        pm(1'b0, 1'b0, 1'b1, 16'hFFFF, 8'h00, {6'h20, 8'h00});
        pm(1'b0, 1'b1, 1'b0, 16'hFE41, 8'h00, {6'h20, 8'hFF});
        pm(1'b0, 1'b0, 1'b0, 16'hFDFF, 8'h00, {6'h20, 8'hFF});
        flash_page_sel <= 8'h7F;
        pm(1'b0, 1'b0, 1'b1, 16'hFE41, 8'h00, {6'h20, 8'hFF});
        repeat (4) @(posedge clock);
        chk("pending", 8'h00, 8'(rq.size() + pq.size()));
        end_of_test;
    end
endmodule
